// ### core/even_halfword_vector_mac.sv
// The register addresses and register access over Wishbone were chosen for this implementation.
module even_halfword_vector_mac
    import mac_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o
);
    logic [63:0] source_a_reg;
    logic [63:0] source_b_reg;
    logic [63:0] dest_r;
    logic [63:0] accumulator_64;
    logic [31:0] instr_r;
    logic [3:0] vector_status_reg;
    logic [2:0] irq_stat_r;
    logic [2:0] irq_mask_r;
    logic ack_r;
    logic [31:0] dat_r;

    logic req;
    logic wr_req;
    logic exec;
    logic [31:0] wdat;
    op_t op;
    logic is_frac;
    logic is_sat;
    logic is_neg;
    logic is_acc;
    logic [31:0] res_w [2];
    logic ovf_w [2];
    logic clamp_w [2];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // Bus handshake: one wait state, ack drops the cycle after
    assign req = cyc_i && stb_i && !ack_r;
    assign wr_req = req && we_i;
    assign exec = wr_req && (adr_i == ADDR_INSTR);
    assign wdat = dat_i;
    assign ack_o = ack_r;
    assign dat_o = dat_r;
    assign irq_o = |(irq_stat_r & irq_mask_r);

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    // Decode of the instruction word being written
    always_comb begin
        op = OP_NONE;
        if (dat_i[31:26] == PRIMARY_OP) begin
            case (dat_i[10:0])
                XO_SF_AAW: op = OP_SF_AAW;
                XO_SF_ANW: op = OP_SF_ANW;
                XO_SI_AAW: op = OP_SI_AAW;
                XO_SI_ANW: op = OP_SI_ANW;
                XO_UM_I: op = OP_UM_I;
                XO_UM_IA: op = OP_UM_IA;
                XO_UM_IAAW: op = OP_UM_IAAW; // see RULE13
                XO_UM_IANW: op = OP_UM_IANW;
                default: op = OP_NONE;
            endcase
        end
    end

    assign is_frac = (op == OP_SF_AAW) || (op == OP_SF_ANW);
    assign is_sat = is_frac || (op == OP_SI_AAW) || (op == OP_SI_ANW);
    assign is_neg = (op == OP_SF_ANW) || (op == OP_SI_ANW) || (op == OP_UM_IANW);
    assign is_acc = (op == OP_UM_IAAW) || (op == OP_UM_IANW);

    // Per-word datapath, word 1 is the high word
    for (genvar w = 0; w < 2; w++) begin : g_word // see RULE14
        logic signed [15:0] a_h;
        logic signed [15:0] b_h;
        logic signed [31:0] prod_s;
        logic [31:0] prod_u;
        logic [31:0] acc_w;
        logic [31:0] addend;
        logic [32:0] s_sum;
        logic [32:0] u_sum;
        logic aov;
        logic clamp;

        assign a_h = source_a_reg[32*w+16 +: 16];
        assign b_h = source_b_reg[32*w+16 +: 16];
        assign acc_w = accumulator_64[32*w +: 32];
        assign prod_s = a_h * b_h;
        assign prod_u = {16'h0000, a_h} * {16'h0000, b_h};
        assign clamp = (a_h == FRAC_MINUS_ONE) && (b_h == FRAC_MINUS_ONE); // see RULE2

        always_comb begin
            if (is_frac) begin
                addend = clamp ? SAT_POS : {prod_s[30:0], 1'b0}; // see RULE1
            end else begin
                addend = prod_s; // see RULE7
            end
        end

        always_comb begin
            if (is_neg) begin
                s_sum = {acc_w[31], acc_w} - {addend[31], addend}; // see RULE4
                u_sum = {1'b0, acc_w} - {1'b0, prod_u}; // see RULE12
            end else begin
                s_sum = {acc_w[31], acc_w} + {addend[31], addend}; // see RULE3
                u_sum = {1'b0, acc_w} + {1'b0, prod_u}; // see RULE11
            end
        end

        assign aov = s_sum[32] ^ s_sum[31];

        always_comb begin
            if (is_sat) begin
                if (aov) begin
                    res_w[w] = s_sum[32] ? SAT_NEG : SAT_POS; // see RULE3
                end else begin
                    res_w[w] = s_sum[31:0];
                end
            end else if (is_acc) begin
                res_w[w] = u_sum[31:0];
            end else begin
                res_w[w] = prod_u; // see RULE9
            end
        end

        assign ovf_w[w] = aov || (is_frac && clamp); // see RULE6
        assign clamp_w[w] = is_frac && clamp;
    end

    // Operand and instruction registers
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            source_a_reg <= {WORD_RESET, WORD_RESET};
            source_b_reg <= {WORD_RESET, WORD_RESET};
            instr_r <= WORD_RESET;
        end else if (wr_req) begin
            case (adr_i)
                ADDR_SRCA_LO: source_a_reg[31:0] <= merge(source_a_reg[31:0], wdat, sel_i);
                ADDR_SRCA_HI: source_a_reg[63:32] <= merge(source_a_reg[63:32], wdat, sel_i);
                ADDR_SRCB_LO: source_b_reg[31:0] <= merge(source_b_reg[31:0], wdat, sel_i);
                ADDR_SRCB_HI: source_b_reg[63:32] <= merge(source_b_reg[63:32], wdat, sel_i);
                ADDR_INSTR: instr_r <= wdat;
                default: instr_r <= instr_r;
            endcase
        end
    end

    // Destination result, written by every valid instruction
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            dest_r <= {WORD_RESET, WORD_RESET};
        end else if (exec && (op != OP_NONE)) begin
            dest_r <= {res_w[1], res_w[0]}; // see RULE5
        end
    end

    // Accumulator: software writes or instruction results
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            accumulator_64 <= {WORD_RESET, WORD_RESET};
        end else if (exec && (op != OP_NONE) && (op != OP_UM_I)) begin
            accumulator_64 <= {res_w[1], res_w[0]}; // see RULE5, RULE10
        end else if (wr_req && (adr_i == ADDR_ACC_LO)) begin
            accumulator_64[31:0] <= merge(accumulator_64[31:0], wdat, sel_i);
        end else if (wr_req && (adr_i == ADDR_ACC_HI)) begin
            accumulator_64[63:32] <= merge(accumulator_64[63:32], wdat, sel_i);
        end
    end

    // Vector status: sticky bits clear on write-one, a new overflow wins
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            vector_status_reg <= VSTAT_RESET;
        end else if (exec && is_sat) begin
            vector_status_reg[VS_OV] <= ovf_w[0]; // see RULE15, RULE8
            vector_status_reg[VS_OVH] <= ovf_w[1];
            vector_status_reg[VS_SOV] <= vector_status_reg[VS_SOV] | ovf_w[0];
            vector_status_reg[VS_HIGH_WORD_STICKY_OVERFLOW] <= vector_status_reg[VS_HIGH_WORD_STICKY_OVERFLOW] | ovf_w[1];
        end else if (wr_req && (adr_i == ADDR_VSTAT) && sel_i[0]) begin
            vector_status_reg[VS_SOV] <= vector_status_reg[VS_SOV] & ~wdat[VS_SOV];
            vector_status_reg[VS_HIGH_WORD_STICKY_OVERFLOW] <= vector_status_reg[VS_HIGH_WORD_STICKY_OVERFLOW] & ~wdat[VS_HIGH_WORD_STICKY_OVERFLOW];
        end
    end // modulo forms fall through unchanged: see RULE16

    // Interrupt status and mask
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_stat_r <= IRQ_RESET;
            irq_mask_r <= IRQ_RESET;
        end else begin
            if (wr_req && (adr_i == ADDR_IRQ_STAT) && sel_i[0]) begin
                irq_stat_r <= irq_stat_r & ~wdat[2:0];
            end else if (exec) begin
                irq_stat_r[IRQ_DONE] <= irq_stat_r[IRQ_DONE] | (op != OP_NONE);
                irq_stat_r[IRQ_OVF] <= irq_stat_r[IRQ_OVF] | (is_sat && (ovf_w[0] || ovf_w[1]));
                irq_stat_r[IRQ_ILLEGAL] <= irq_stat_r[IRQ_ILLEGAL] | (op == OP_NONE);
            end
            if (wr_req && (adr_i == ADDR_IRQ_MASK) && sel_i[0]) begin
                irq_mask_r <= wdat[2:0];
            end
        end
    end

    // Read data, captured with the ack
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            dat_r <= WORD_RESET;
        end else if (req && !we_i) begin
            case (adr_i)
                ADDR_SRCA_LO: dat_r <= source_a_reg[31:0];
                ADDR_SRCA_HI: dat_r <= source_a_reg[63:32];
                ADDR_SRCB_LO: dat_r <= source_b_reg[31:0];
                ADDR_SRCB_HI: dat_r <= source_b_reg[63:32];
                ADDR_INSTR: dat_r <= instr_r;
                ADDR_DEST_LO: dat_r <= dest_r[31:0];
                ADDR_DEST_HI: dat_r <= dest_r[63:32];
                ADDR_ACC_LO: dat_r <= accumulator_64[31:0];
                ADDR_ACC_HI: dat_r <= accumulator_64[63:32];
                ADDR_VSTAT: dat_r <= {28'h0000000, vector_status_reg};
                ADDR_IRQ_STAT: dat_r <= {29'h0, irq_stat_r};
                ADDR_IRQ_MASK: dat_r <= {29'h0, irq_mask_r};
                default: dat_r <= WORD_RESET;
            endcase
        end
    end

    clamp_result_a: assert property ( // see RULE2
        @(posedge mclk_i) disable iff (rst_i)
        (exec && op == OP_SF_AAW && clamp_w[1] && accumulator_64[63:32] == WORD_RESET)
        |=> (dest_r[63:32] == SAT_POS) && vector_status_reg[VS_OVH])
        else $error("clamped product not saturated");

    add_sat_pos_a: assert property ( // see RULE3
        @(posedge mclk_i) disable iff (rst_i)
        (exec && op == OP_SI_AAW && accumulator_64[31:0] == SAT_POS
         && !source_a_reg[31] && !source_b_reg[31] && source_a_reg[30:16] != 15'h0000
         && source_b_reg[30:16] != 15'h0000)
        |=> dest_r[31:0] == SAT_POS && vector_status_reg[VS_OV])
        else $error("positive overflow not saturated");

    neg_sat_a: assert property ( // see RULE4
        @(posedge mclk_i) disable iff (rst_i)
        (exec && is_sat && is_neg && ovf_w[0] && !clamp_w[0])
        |=> dest_r[31:0] == SAT_NEG || dest_r[31:0] == SAT_POS)
        else $error("difference overflow not saturated");

    acc_dest_match_a: assert property ( // see RULE5
        @(posedge mclk_i) disable iff (rst_i)
        (exec && op != OP_NONE && op != OP_UM_I) |=> accumulator_64 == dest_r)
        else $error("accumulator and destination differ");

    sticky_or_a: assert property ( // see RULE15
        @(posedge mclk_i) disable iff (rst_i)
        (exec && is_sat && ovf_w[1])
        |=> vector_status_reg[VS_HIGH_WORD_STICKY_OVERFLOW] && vector_status_reg[VS_OVH]
            ##1 vector_status_reg[VS_HIGH_WORD_STICKY_OVERFLOW])
        else $error("sticky high overflow lost");

    modulo_status_a: assert property ( // see RULE16
        @(posedge mclk_i) disable iff (rst_i)
        (exec && !is_sat && op != OP_NONE) |=> $stable(vector_status_reg))
        else $error("modulo form altered status");

    umul_copy_a: assert property ( // see RULE10
        @(posedge mclk_i) disable iff (rst_i)
        (exec && op == OP_UM_IA) |=> accumulator_64 == dest_r
            && dest_r[31:0] == $past(source_a_reg[31:16]) * $past(source_b_reg[31:16]))
        else $error("unsigned product not copied");

    umul_keep_acc_a: assert property ( // see RULE9
        @(posedge mclk_i) disable iff (rst_i)
        (exec && op == OP_UM_I) |=> $stable(accumulator_64)
            && dest_r[63:32] == $past(source_a_reg[63:48]) * $past(source_b_reg[63:48]))
        else $error("plain multiply touched accumulator");

    mod_add_a: assert property ( // see RULE11
        @(posedge mclk_i) disable iff (rst_i)
        (exec && op == OP_UM_IAAW) |=> dest_r[31:0] == 32'($past(accumulator_64[31:0])
            + $past(source_a_reg[31:16]) * $past(source_b_reg[31:16])))
        else $error("modulo sum wrong");

    ack_pulse_a: assert property (
        @(posedge mclk_i) disable iff (rst_i)
        ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
endmodule : even_halfword_vector_mac

// ### dv/test_even_halfword_vector_mac.sv
module test_even_halfword_vector_mac
    import mac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {op_t op; logic [10:0] xo; logic [63:0] a; logic [63:0] b;} case_t;

    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc, stb, we, ack, irq;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    int fails = 0;
    int check_count = 0;
    logic [63:0] exp_acc;
    logic [3:0] exp_vs;
    case_t cases [10] = '{
        '{OP_SF_AAW, XO_SF_AAW, 64'h80001234_4000ffff, 64'h80005678_40000000},
        '{OP_SF_ANW, XO_SF_ANW, 64'h7fff0000_7fff0000, 64'h80000000_80010000},
        '{OP_SI_AAW, XO_SI_AAW, 64'h80000000_7fff0000, 64'h7fff0000_7fff0000},
        '{OP_SI_ANW, XO_SI_ANW, 64'h7fff0000_80000000, 64'h80000000_80000000},
        '{OP_UM_I, XO_UM_I, 64'hffff0000_1234abcd, 64'hffff0000_00100000},
        '{OP_UM_IA, XO_UM_IA, 64'hffff0000_00030000, 64'h80010000_00050000},
        '{OP_SI_AAW, XO_SI_AAW, 64'h80000000_00010000, 64'h7fff0000_00020000},
        '{OP_UM_IAAW, XO_UM_IAAW, 64'hffff0000_ffff0000, 64'hffff0000_ffff0000},
        '{OP_UM_IANW, XO_UM_IANW, 64'hffff0000_ffff0000, 64'hffff0000_ffff0000},
        '{OP_SF_ANW, XO_SF_ANW, 64'h80000000_7fff0000, 64'h80000000_7fff0000}
    };

    always #5 mclk_i = ~mclk_i;

    wb_master_model master_inst (.mclk_i(mclk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc),
        .stb_o(stb), .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    even_halfword_vector_mac even_halfword_vector_mac_inst (.mclk_i(mclk_i), .rst_i(rst_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
        .dat_o(rdat), .ack_o(ack), .irq_o(irq));

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        master_inst.access(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string what);
        logic [31:0] r;
        master_inst.access(1'b0, a, 32'h00000000, r);
        chk(r, e, what);
    endtask : rd_chk

    // Expected {overflow, word} of one word element
    function automatic logic [32:0] word_ref(input op_t op, input logic [31:0] a,
                                             input logic [31:0] b, input logic [31:0] acc);
        logic [31:0] p;
        logic [32:0] s;
        logic mov;
        logic ovf;
        mov = 1'b0;
        p = 32'($signed(a[31:16]) * $signed(b[31:16]));
        if (op == OP_SF_AAW || op == OP_SF_ANW) begin
            mov = (a[31:16] == FRAC_MINUS_ONE) && (b[31:16] == FRAC_MINUS_ONE);
            p = mov ? SAT_POS : {p[30:0], 1'b0};
        end
        if (op inside {OP_UM_I, OP_UM_IA, OP_UM_IAAW, OP_UM_IANW}) begin
            p = 32'(a[31:16] * b[31:16]);
        end
        if (op inside {OP_SF_ANW, OP_SI_ANW, OP_UM_IANW}) begin
            s = {acc[31], acc} - {p[31], p};
        end else begin
            s = {acc[31], acc} + {p[31], p};
        end
        if (op inside {OP_UM_I, OP_UM_IA}) begin
            return {1'b0, p};
        end
        if (op inside {OP_UM_IAAW, OP_UM_IANW}) begin
            return {1'b0, s[31:0]};
        end
        ovf = s[32] ^ s[31];
        return {mov | ovf, ovf ? (s[32] ? SAT_NEG : SAT_POS) : s[31:0]};
    endfunction : word_ref

    task automatic run_op(input case_t c);
        logic [32:0] hi, lo;
        logic [63:0] d;
        logic sat;
        logic ev;
        wr(ADDR_SRCA_LO, c.a[31:0]);
        wr(ADDR_SRCA_HI, c.a[63:32]);
        wr(ADDR_SRCB_LO, c.b[31:0]);
        wr(ADDR_SRCB_HI, c.b[63:32]);
        wr(ADDR_INSTR, {PRIMARY_OP, 15'h0000, c.xo});
        hi = word_ref(c.op, c.a[63:32], c.b[63:32], exp_acc[63:32]);
        lo = word_ref(c.op, c.a[31:0], c.b[31:0], exp_acc[31:0]);
        d = {hi[31:0], lo[31:0]};
        sat = c.op inside {OP_SF_AAW, OP_SF_ANW, OP_SI_AAW, OP_SI_ANW};
        if (c.op != OP_UM_I) begin
            exp_acc = d;
        end
        if (sat) begin
            exp_vs = {exp_vs[3] | hi[32], exp_vs[2] | lo[32], hi[32], lo[32]};
        end
        rd_chk(ADDR_DEST_LO, d[31:0], "dest lo");
        rd_chk(ADDR_DEST_HI, d[63:32], "dest hi");
        rd_chk(ADDR_ACC_LO, exp_acc[31:0], "acc lo");
        rd_chk(ADDR_ACC_HI, exp_acc[63:32], "acc hi");
        rd_chk(ADDR_VSTAT, {28'h0000000, exp_vs}, "status");
        ev = sat & (hi[32] | lo[32]);
        rd_chk(ADDR_IRQ_STAT, {29'h0, 1'b0, ev, 1'b1}, "events");
        wr(ADDR_IRQ_STAT, 32'h00000007);
        $display("test %s finished", c.op.name());
    endtask : run_op

    initial begin
        #100us;
        fails++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end

    initial begin
        exp_acc = 64'h0;
        exp_vs = VSTAT_RESET;
        repeat (16) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd_chk(ADDR_VSTAT, 32'h00000000, "status reset");
        rd_chk(ADDR_IRQ_STAT, 32'h00000000, "events reset");
        wr(ADDR_INSTR, {6'h05, 15'h0000, XO_UM_IAAW});
        wr(ADDR_INSTR, {PRIMARY_OP, 15'h0000, 11'h7ff});
        rd_chk(ADDR_IRQ_STAT, 32'h00000004, "illegal event");
        rd_chk(ADDR_INSTR, {PRIMARY_OP, 15'h0000, 11'h7ff}, "instr readback");
        rd_chk(ADDR_ACC_LO, 32'h00000000, "acc after illegal");
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(ADDR_IRQ_MASK, 32'h00000004);
        chk({31'h0, irq}, 32'h1, "irq unmasked");
        wr(ADDR_IRQ_STAT, 32'h00000004);
        chk({31'h0, irq}, 32'h0, "irq cleared");
        $display("test events finished");
        foreach (cases[i]) begin
            run_op(cases[i]);
        end
        wr(ADDR_VSTAT, 32'h0000000c);
        exp_vs[3:2] = 2'b00;
        rd_chk(ADDR_VSTAT, {28'h0000000, exp_vs}, "sticky cleared");
        wr(8'h30, 32'hffffffff);
        rd_chk(8'h30, 32'h00000000, "unmapped");
        $display("test status finished");
        end_of_test();
    end
endmodule : test_even_halfword_vector_mac

// ### dv/wb_master_model.sv
module wb_master_model (
    input wire logic mclk_i,
    input wire logic ack_i,
    input wire logic [31:0] dat_i,
    output logic cyc_o,
    output logic stb_o,
    output logic we_o,
    output logic [7:0] adr_o,
    output logic [3:0] sel_o,
    output logic [31:0] dat_o
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h00000000;
    end

    // Classic single cycle, held until ack is sampled high
    task automatic access(input logic wr, input logic [7:0] adr, input logic [31:0] wdat,
                          output logic [31:0] rdat);
        @(posedge mclk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= wr;
        adr_o <= adr;
        sel_o <= 4'hf;
        dat_o <= wdat;
        // Only the bench watchdog ends a wait for ack
        do begin
            @(posedge mclk_i);
        end while (ack_i !== 1'b1);
        rdat = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o <= 1'b0;
        // Released lines do not keep the last value
        adr_o <= ~adr;
        dat_o <= ~wdat;
    endtask : access
endmodule : wb_master_model

// ### shared/mac_pkg.sv
// Function
// RULE1: Fractional saturating forms shift each 32-bit even halfword product left by one.
// RULE2: Two minus-one fraction inputs clamp the product to most positive, counted as overflow.
// RULE3: Saturating add-accumulate gives 0x7fffffff or 0x80000000 on overflow, else low 32 bits.
// RULE4: Saturating negative-accumulate subtracts product from accumulator word, saturating.
// RULE5: Every accumulate form writes the final word to the accumulator and destination words.
// RULE6: Fractional forms flag word overflow when clamp or accumulation saturated.
// RULE7: Integer saturating add-accumulate does not shift and flags only addition overflow.
// RULE8: Integer negative-accumulate records subtraction overflow in word and summary flags.
// RULE9: Unsigned modulo multiply places the two 32-bit even products in the destination words.
// RULE10: The to-accumulator unsigned multiply also copies the 64-bit result to the accumulator.
// RULE11: Unsigned modulo add-accumulate keeps the low 32 bits of a 33-bit sum, unsaturated.
// RULE12: Unsigned modulo negative-accumulate keeps the low 32 bits of a 33-bit difference.
// RULE13: Unsigned modulo add-accumulate decodes from primary opcode 4, extended 101 0000 1000.
// RULE14: Multiply and accumulate run independently on high and low words, in order per word.
// RULE15: Word overflow flags take the current overflow, also ORed into sticky summary flags.
// RULE16: Modulo forms leave the vector status register unchanged.
package mac_pkg;
    localparam logic [7:0] ADDR_SRCA_LO = 8'h00;
    localparam logic [7:0] ADDR_SRCA_HI = 8'h04;
    localparam logic [7:0] ADDR_SRCB_LO = 8'h08;
    localparam logic [7:0] ADDR_SRCB_HI = 8'h0c;
    localparam logic [7:0] ADDR_INSTR = 8'h10;
    localparam logic [7:0] ADDR_DEST_LO = 8'h14;
    localparam logic [7:0] ADDR_DEST_HI = 8'h18;
    localparam logic [7:0] ADDR_ACC_LO = 8'h1c;
    localparam logic [7:0] ADDR_ACC_HI = 8'h20;
    localparam logic [7:0] ADDR_VSTAT = 8'h24;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h28;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h2c;

    localparam logic [5:0] PRIMARY_OP = 6'h04;
    localparam logic [10:0] XO_SF_AAW = 11'h503;
    localparam logic [10:0] XO_SF_ANW = 11'h583;
    localparam logic [10:0] XO_SI_AAW = 11'h501;
    localparam logic [10:0] XO_SI_ANW = 11'h581;
    localparam logic [10:0] XO_UM_I = 11'h408;
    localparam logic [10:0] XO_UM_IA = 11'h428;
    localparam logic [10:0] XO_UM_IAAW = 11'h508;
    localparam logic [10:0] XO_UM_IANW = 11'h588;

    localparam int VS_OV = 0;
    localparam int VS_OVH = 1;
    localparam int VS_SOV = 2;
    localparam int VS_HIGH_WORD_STICKY_OVERFLOW = 3;
    localparam int IRQ_DONE = 0;
    localparam int IRQ_OVF = 1;
    localparam int IRQ_ILLEGAL = 2;

    localparam logic [31:0] SAT_POS = 32'h7fffffff;
    localparam logic [31:0] SAT_NEG = 32'h80000000;
    localparam logic [15:0] FRAC_MINUS_ONE = 16'h8000;
    localparam logic [31:0] WORD_RESET = 32'h00000000;
    localparam logic [3:0] VSTAT_RESET = 4'h0;
    localparam logic [2:0] IRQ_RESET = 3'h0;

    typedef enum logic [3:0] {
        OP_NONE, OP_SF_AAW, OP_SF_ANW, OP_SI_AAW, OP_SI_ANW,
        OP_UM_I, OP_UM_IA, OP_UM_IAAW, OP_UM_IANW
    } op_t;
endpackage : mac_pkg
